// ===== src/cpmc_device.sv
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
// Clock and power mode block: builds the CPU clock from one of two
// oscillators and sequences stop and wait modes.
module cpmc_device
  import cpmc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  cpmc_link_if.dev link,
  input wire logic mainOscInput,
  input wire logic subOscInput,
  input wire logic extIrqOne,
  input wire logic extIrqTwo,
  input wire logic serialIrq,
  input wire logic resetHighVolt,
  input wire logic singleChip,
  input wire logic syncFetch,
  output logic phiClock,
  output logic mainOscEnable,
  output logic subOscEnable,
  output logic oscOutPin
);

  // Whole state of the block, registered as one word.
  typedef struct packed {
    cpmc_state_t state;       // Power state.
    logic [2:0] mainSync;     // Main oscillator synchroniser plus edge stage.
    logic [2:0] subSync;      // Sub oscillator synchroniser plus edge stage.
    logic [1:0] irq1Sync;     // External interrupt one synchroniser.
    logic [1:0] irq2Sync;     // External interrupt two synchroniser.
    logic [1:0] serSync;      // Serial interrupt synchroniser.
    logic [1:0] hvSync;       // High-voltage reset detect synchroniser.
    logic [7:0] modeA;        // Clock select, low power, sync select, display.
    logic [7:0] modeB;        // Main halt and sub oscillator enable.
    logic [TMR_W-1:0] t1;     // Wake timer 1 count.
    logic [TMR_W-1:0] t2;     // Wake timer 2 count.
    logic [3:0] pre;          // Wake prescaler.
    logic divCnt;             // Half of the main divide-by-four.
    logic phi;                // Internal clock level.
    logic actSel;             // Source in use: 1 sub, 0 main.
    logic mainEn;             // Main oscillator enable.
    logic subEn;              // Sub oscillator enable.
    logic oscOut;             // Oscillator output pin level.
  } cpmc_dev_t;

  // Value taken on reset: run mode, clock high, main source.
  localparam cpmc_dev_t DEV_RST = '{
    state: ST_RUN, mainSync: 3'h0_0, subSync: 3'h0_0, irq1Sync: 2'h0_0,
    irq2Sync: 2'h0_0, serSync: 2'h0_0, hvSync: 2'h0_0, modeA: MODE_A_RST,
    modeB: MODE_B_RST, t1: '0, t2: '0, pre: 4'h0_000, divCnt: 1'b0,
    phi: 1'b1, actSel: 1'b0, mainEn: 1'b1, subEn: 1'b0, oscOut: 1'b0};

  cpmc_dev_t st;
  cpmc_dev_t next_st;
  logic mainEdge;     // Rising edge of the synchronised main oscillator.
  logic subEdge;      // Rising edge of the synchronised sub oscillator.
  logic srcEdge;      // Rising edge of the source now in use.
  logic irqHit;       // An enabled wake interrupt is pending.
  logic preLast;      // Prescaler reached its terminal count.
  logic clkSel;       // Requested source, 1 for sub.
  logic mainHalt;     // Main oscillator halted by software.

  // Next-state logic for the whole block.
  always_comb begin
    next_st = st;
    // Two stages before any use; stage 0 feeds only stage 1.
    next_st.mainSync = {st.mainSync[1:0], mainOscInput};
    next_st.subSync = {st.subSync[1:0], subOscInput};
    next_st.irq1Sync = {st.irq1Sync[0], extIrqOne};
    next_st.irq2Sync = {st.irq2Sync[0], extIrqTwo};
    next_st.serSync = {st.serSync[0], serialIrq};
    next_st.hvSync = {st.hvSync[0], resetHighVolt};
    mainEdge = st.mainSync[1] & ~st.mainSync[2];
    subEdge = st.subSync[1] & ~st.subSync[2];
    srcEdge = st.actSel ? subEdge : mainEdge;
    irqHit = |(link.irqEnable & {st.serSync[1], st.irq2Sync[1], st.irq1Sync[1]});
    preLast = st.actSel ? (st.pre == SUB_PRE_LAST) : (st.pre == MAIN_PRE_LAST);

    // Mode register writes from the core.
    if (link.regWrite) begin
      if (link.regAddr == ADDR_MODE_A) begin
        next_st.modeA = link.regWdata;
      end else if (link.regAddr == ADDR_MODE_B) begin
        next_st.modeB = link.regWdata;
      end
    end
    clkSel = next_st.modeA[BIT_CLK_SEL];
    mainHalt = next_st.modeB[BIT_MAIN_HALT];

    // Low-power bit cannot stay set without the oscillators to back it.
    if (!next_st.modeB[BIT_SUB_EN] || (!clkSel && mainHalt)) begin
      next_st.modeA[BIT_LOW_PWR] = 1'b0;
    end

    // Power state sequencing.
    case (st.state)
      ST_RUN: begin
        if (link.stopInstr) begin
          // Timers take their reload values at the stop instruction itself.
          next_st.state = ST_STOP;
          next_st.t1 = link.t1Load;
          next_st.t2 = link.t2Load;
          next_st.pre = 4'h0_000;
        end else if (link.waitInstr) begin
          next_st.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Oscillator never stopped, so the clock returns at once.
        if (irqHit) begin
          next_st.state = ST_RUN;
        end
      end
      ST_STOP: begin
        if (irqHit) begin
          next_st.state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Source divided by 16 or 8 steps timer 1, whose underflow steps timer 2.
        if (srcEdge) begin
          if (preLast) begin
            next_st.pre = 4'h0_000;
            if (st.t1 == '0) begin
              next_st.t1 = link.t1Load;
              if (st.t2 == '0) begin
                next_st.state = ST_RUN;
              end else begin
                next_st.t2 = st.t2 - 1'b1;
              end
            end else begin
              next_st.t1 = st.t1 - 1'b1;
            end
          end else begin
            next_st.pre = st.pre + 4'h0_001;
          end
        end
      end
      default: begin
        next_st.state = ST_RUN;
      end
    endcase

    // Oscillators are off only in stop, when software halts main, or while the sub enable bit is clear.
    next_st.mainEn = (next_st.state != ST_STOP) && !mainHalt;
    next_st.subEn = (next_st.state != ST_STOP) && next_st.modeB[BIT_SUB_EN];

    // Internal clock: held high from the very edge that leaves run, so the stop
    // or wait edge can never drop it; else main/4 or sub/2.
    if (next_st.state != ST_RUN) begin
      next_st.phi = 1'b1;
      next_st.divCnt = 1'b0;
    end else begin
      // Source swaps only while the clock is high, in the first half of a high phase on main,
      // so the phase carrying the swap may grow or be cut short; growth is up to one extra half period.
      if (st.phi && !st.divCnt && !srcEdge) begin
        next_st.actSel = clkSel;
      end
      if (srcEdge) begin
        if (st.actSel) begin
          next_st.phi = ~st.phi;
        end else begin
          next_st.divCnt = ~st.divCnt;
          if (st.divCnt) begin
            next_st.phi = ~st.phi;
          end
        end
      end
    end

    // Oscillator output pin routing.
    if (singleChip) begin
      next_st.oscOut = st.mainSync[1];
    end else if (st.hvSync[1]) begin
      next_st.oscOut = syncFetch;
    end else if (st.modeA[BIT_SYNC_SEL] && !(st.modeA[BIT_CLK_SEL] && mainHalt)) begin
      next_st.oscOut = syncFetch;
    end else begin
      next_st.oscOut = st.mainSync[1];
    end
  end

  // State register; reset from either side leaves stop with no wait.
  always_ff @(posedge mclk) begin
    if (rst || link.linkReset) begin
      st <= DEV_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs straight from the state word.
  assign phiClock = st.phi;
  assign mainOscEnable = st.mainEn;
  assign subOscEnable = st.subEn;
  assign oscOutPin = st.oscOut;
  assign link.devState = st.state;
  assign link.devModeA = st.modeA;
  assign link.devModeB = st.modeB;

endmodule // cpmc_device

// ===== src/cpmc_host.sv
`timescale 1ns/100ps
// Controller: takes orders from software over APB and drives the block,
// refusing orders that would break the block's usage rules.
module cpmc_host
  import cpmc_pkg::*;
#(
  parameter int STAB_CYC = OSC_STAB_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  cpmc_link_if.host link
);

  // Settling counters must be at least one cycle and fit their field.
  if (STAB_CYC < 1 || STAB_CYC > 1048575) begin : gChk
    $error("STAB_CYC out of range");
  end

  // Whole controller state.
  typedef struct packed {
    logic [7:0] modeA;        // Shadow of mode register A.
    logic [7:0] modeB;        // Shadow of mode register B.
    logic [TMR_W-1:0] t1;     // Timer 1 value to send with stop.
    logic [TMR_W-1:0] t2;     // Timer 2 value to send with stop.
    logic [2:0] irqEn;        // Wake interrupt enables.
    logic [19:0] stab;        // Settling countdown.
    logic refused;            // Sticky: last order was refused.
    logic regWrite;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic stopInstr;
    logic waitInstr;
    logic linkReset;
    logic [31:0] rdata;
  } cpmc_host_t;

  localparam cpmc_host_t HOST_RST = '{
    modeA: MODE_A_RST, modeB: MODE_B_RST, t1: '0, t2: '0, irqEn: 3'h0_0,
    stab: 20'h0_0000, refused: 1'b0, regWrite: 1'b0, regAddr: 8'h00_00,
    regWdata: 8'h00_00, stopInstr: 1'b0, waitInstr: 1'b0, linkReset: 1'b0,
    rdata: 32'h0000_0000};

  cpmc_host_t st;
  cpmc_host_t next_st;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] wb;

  // Order handling and register reads.
  always_comb begin
    next_st = st;
    next_st.regWrite = 1'b0;
    next_st.stopInstr = 1'b0;
    next_st.waitInstr = 1'b0;
    wb = pwdata[7:0];
    mapped = (paddr == OFS_MODE_A) || (paddr == OFS_MODE_B) || (paddr == OFS_TIMER) ||
             (paddr == OFS_CMD) || (paddr == OFS_STATUS);
    wr = psel && penable && pwrite && mapped;
    rd = psel && !penable && !pwrite;
    if (st.stab != 20'h0_0000) begin
      next_st.stab = st.stab - 20'h0_0001;
    end
    if (st.linkReset && st.stab == 20'h0_0001) begin
      // Shadows follow the block back to its reset values.
      next_st.linkReset = 1'b0;
      next_st.modeA = MODE_A_RST;
      next_st.modeB = MODE_B_RST;
    end
    if (wr) begin
      if (paddr == OFS_MODE_A) begin
        // Switch to sub needs the sub oscillator on; back to main needs it settled.
        if ((wb[BIT_CLK_SEL] && !st.modeB[BIT_SUB_EN]) ||
            (!wb[BIT_CLK_SEL] && st.modeA[BIT_CLK_SEL] &&
             (st.modeB[BIT_MAIN_HALT] || st.stab != 20'h0_0000))) begin
          next_st.refused = 1'b1;
        end else begin
          next_st.modeA = wb;
          next_st.regWrite = 1'b1;
          next_st.regAddr = ADDR_MODE_A;
          next_st.regWdata = wb;
        end
      end else if (paddr == OFS_MODE_B) begin
        if (st.modeA[BIT_CLK_SEL] && !wb[BIT_SUB_EN]) begin
          next_st.refused = 1'b1;
        end else begin
          if (st.modeB[BIT_MAIN_HALT] && !wb[BIT_MAIN_HALT]) begin
            next_st.stab = 20'(STAB_CYC);
          end
          next_st.modeB = wb;
          next_st.regWrite = 1'b1;
          next_st.regAddr = ADDR_MODE_B;
          next_st.regWdata = wb;
        end
      end else if (paddr == OFS_TIMER) begin
        next_st.t1 = pwdata[TMR_W-1:0];
        next_st.t2 = pwdata[8 +: TMR_W];
      end else if (paddr == OFS_CMD) begin
        next_st.irqEn = pwdata[6:4];
        if (pwdata[2]) begin
          next_st.linkReset = 1'b1;
          next_st.stab = 20'(STAB_CYC);
        end else if (pwdata[0]) begin
          // Stop needs a wake source and must not starve the display timers.
          if (pwdata[6:4] == 3'h0_0 || st.modeA[BIT_DISP_EN]) begin
            next_st.refused = 1'b1;
          end else begin
            next_st.stopInstr = 1'b1;
          end
        end else if (pwdata[1]) begin
          if (pwdata[6:4] == 3'h0_0) begin
            next_st.refused = 1'b1;
          end else begin
            next_st.waitInstr = 1'b1;
          end
        end
      end else if (paddr == OFS_STATUS) begin
        if (pwdata[0]) begin
          next_st.refused = 1'b0;
        end
      end
    end
    if (rd) begin
      if (paddr == OFS_MODE_A) begin
        next_st.rdata = {24'h00_0000, link.devModeA};
      end else if (paddr == OFS_MODE_B) begin
        next_st.rdata = {24'h00_0000, link.devModeB};
      end else if (paddr == OFS_TIMER) begin
        next_st.rdata = {16'h0000, st.t2, st.t1};
      end else if (paddr == OFS_CMD) begin
        next_st.rdata = {25'h000_0000, st.irqEn, 4'h0};
      end else if (paddr == OFS_STATUS) begin
        next_st.rdata = {24'h00_0000, link.devState, 1'b0, st.linkReset,
                         st.stab != 20'h0_0000, st.refused};
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= HOST_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Answer in the first access cycle; unmapped offsets flag an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = st.rdata;
  assign link.regWrite = st.regWrite;
  assign link.regAddr = st.regAddr;
  assign link.regWdata = st.regWdata;
  assign link.stopInstr = st.stopInstr;
  assign link.waitInstr = st.waitInstr;
  assign link.t1Load = st.t1;
  assign link.t2Load = st.t2;
  assign link.irqEnable = st.irqEn;
  assign link.linkReset = st.linkReset;

endmodule // cpmc_host

// ===== src/cpmc_link_if.sv
`timescale 1ns/100ps
// Same-clock link between the controller and the clock block.
interface cpmc_link_if;
  import cpmc_pkg::*;
  logic regWrite;             // One-cycle write strobe to a mode register.
  logic [7:0] regAddr;        // Mode register address.
  logic [7:0] regWdata;       // Mode register write data.
  logic stopInstr;            // One-cycle stop instruction pulse.
  logic waitInstr;            // One-cycle wait instruction pulse.
  logic [TMR_W-1:0] t1Load;   // Timer 1 reload value.
  logic [TMR_W-1:0] t2Load;   // Timer 2 reload value.
  logic [2:0] irqEnable;      // Enables: [0] ext one, [1] ext two, [2] serial.
  logic linkReset;            // Reset driven by the controller, active high.
  logic [3:0] devState;       // Device power state, one-hot.
  logic [7:0] devModeA;       // Readback of mode register A.
  logic [7:0] devModeB;       // Readback of mode register B.
  modport host (output regWrite, regAddr, regWdata, stopInstr, waitInstr, t1Load, t2Load,
                irqEnable, linkReset, input devState, devModeA, devModeB);
  modport dev (input regWrite, regAddr, regWdata, stopInstr, waitInstr, t1Load, t2Load,
               irqEnable, linkReset, output devState, devModeA, devModeB);
endinterface // cpmc_link_if

// ===== src/cpmc_pkg.sv
package cpmc_pkg;

  // Device mode registers as seen on the device's own register port.
  localparam logic [7:0] ADDR_MODE_A = 8'h00_F5;
  localparam logic [7:0] ADDR_MODE_B = 8'h00_F6;
  localparam int BIT_CLK_SEL = 7;
  localparam int BIT_LOW_PWR = 6;
  localparam int BIT_SYNC_SEL = 5;
  localparam int BIT_DISP_EN = 3;
  localparam int BIT_MAIN_HALT = 6;
  localparam int BIT_SUB_EN = 5;
  localparam logic [7:0] MODE_A_RST = 8'h00_00;
  localparam logic [7:0] MODE_B_RST = 8'h00_00;

  // Source edges per wake prescaler tick, as terminal counts.
  localparam logic [3:0] MAIN_PRE_LAST = 4'h0_00F;
  localparam logic [3:0] SUB_PRE_LAST = 4'h0_007;

  // Timer width shared by both ends.
  localparam int TMR_W = 8;

  // Controller register offsets on the APB side.
  localparam logic [7:0] OFS_MODE_A = 8'h00_00;
  localparam logic [7:0] OFS_MODE_B = 8'h00_04;
  localparam logic [7:0] OFS_TIMER = 8'h00_08;
  localparam logic [7:0] OFS_CMD = 8'h00_0C;
  localparam logic [7:0] OFS_STATUS = 8'h00_10;

  // Oscillator settling time in microseconds and its cycle count at mclk.
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_STAB_US = 100;
  localparam int OSC_STAB_CYC = (OSC_STAB_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power state of the device, one-hot.
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_STOP = 4'b0100,
    ST_WAKE = 4'b1000
  } cpmc_state_t;

endpackage

// ===== verification/clock_power_mode_control_tb_top.sv
`timescale 1ns/100ps
// Drives the controller over APB and the clock block's pins; checks both.
module clock_power_mode_control_tb_top;
  import cpmc_pkg::*;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic mainOscInput, subOscInput, extIrqOne, extIrqTwo, serialIrq;
  logic resetHighVolt, singleChip, syncFetch, phiClock, mainOscEnable, subOscEnable, oscOutPin;
  logic e, lowSeen, ce, frozenPhi;
  logic [1:0] mDiv;
  logic [2:0] sDiv;
  int mismatches, n_checks, cyc, n;

  cpmc_link_if link();
  // A short settle count keeps the device reset hold brief.
  cpmc_host #(.STAB_CYC(20)) cpmc_host_inst(.mclk(mclk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  cpmc_device cpmc_device_inst(.mclk(mclk), .rst(rst), .ce(ce), .link(link),
    .mainOscInput(mainOscInput), .subOscInput(subOscInput), .extIrqOne(extIrqOne),
    .extIrqTwo(extIrqTwo), .serialIrq(serialIrq), .resetHighVolt(resetHighVolt),
    .singleChip(singleChip), .syncFetch(syncFetch), .phiClock(phiClock),
    .mainOscEnable(mainOscEnable), .subOscEnable(subOscEnable), .oscOutPin(oscOutPin));
  cpmc_asserts cpmc_asserts_inst(.mclk(mclk), .rst(rst), .regWrite(link.regWrite),
    .regAddr(link.regAddr), .regWdata(link.regWdata), .stopInstr(link.stopInstr),
    .waitInstr(link.waitInstr), .t1Load(link.t1Load), .irqEnable(link.irqEnable),
    .linkReset(link.linkReset), .devState(link.devState), .devModeA(link.devModeA),
    .devModeB(link.devModeB));

  // Clock at 100 MHz.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Oscillators run only while enabled, so a halted one really stands still.
  // Main toggles every 2 cycles, sub every 8, both slow enough for the synchronisers.
  always @(posedge mclk) begin
    if (mainOscEnable === 1'b1) begin
      mDiv <= mDiv + 2'b01;
      if (mDiv[0]) mainOscInput <= ~mainOscInput;
    end
    if (subOscEnable === 1'b1) begin
      sDiv <= sDiv + 3'b001;
      if (sDiv == 3'b111) subOscInput <= ~subOscInput;
    end
  end

  // Cuts a hang short.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, x);
    end
  endtask

  // One APB transfer; an idle edge first so no signal is set twice in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    // Ends on pready; only the bench timeout ends it if pready stays low.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, x);
  endtask

  // Waits for a device state, noting whether the CPU clock ever went low meanwhile.
  task automatic waitst(input logic [3:0] s);
    n = 0;
    lowSeen = 1'b0;
    while (link.devState !== s && n < 2000) begin
      @(posedge mclk);
      n++;
      if (phiClock !== 1'b1) lowSeen = 1'b1;
    end
  endtask

  // Measures one whole high phase of the CPU clock in cycles.
  task automatic phase();
    n = 0;
    while (phiClock !== 1'b0 && n < 200) begin @(posedge mclk); n++; end
    while (phiClock !== 1'b1 && n < 400) begin @(posedge mclk); n++; end
    n = 0;
    while (phiClock === 1'b1 && n < 200) begin @(posedge mclk); n++; end
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, extIrqOne, extIrqTwo, serialIrq} = '0;
    {resetHighVolt, singleChip, syncFetch, mDiv, sDiv, mismatches, n_checks, cyc} = '0;
    {mainOscInput, subOscInput} = 2'b00;
    ce = 1'b1;
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdchk(OFS_STATUS, 32'h0000_0010);
    phase();
    chk(n, 8);
    apb(1'b0, 8'h00_20, 32'h0000_0000);
    chk({r[30:0], e}, 32'h0000_0001);
    // Stop without a wake source, and stop while the display is on, are refused.
    apb(1'b1, OFS_CMD, 32'h0000_0001);
    rdchk(OFS_STATUS, 32'h0000_0011);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    apb(1'b1, OFS_MODE_A, 32'h0000_0008);
    apb(1'b1, OFS_CMD, 32'h0000_0011);
    rdchk(OFS_STATUS, 32'h0000_0011);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    // Low power bit is forced off by the oscillator state.
    apb(1'b1, OFS_MODE_A, 32'h0000_0040);
    rdchk(OFS_MODE_A, 32'h0000_0000);
    apb(1'b1, OFS_MODE_B, 32'h0000_0020);
    apb(1'b1, OFS_MODE_A, 32'h0000_0040);
    rdchk(OFS_MODE_A, 32'h0000_0040);
    apb(1'b1, OFS_MODE_B, 32'h0000_0060);
    rdchk(OFS_MODE_A, 32'h0000_0000);
    chk(mainOscEnable, 1'b0);
    apb(1'b1, OFS_MODE_B, 32'h0000_0020);
    repeat (3) @(posedge mclk);
    chk(mainOscEnable, 1'b1);
    // Switch to the sub clock and back; the phase length follows the source.
    apb(1'b1, OFS_MODE_A, 32'h0000_0080);
    // The phase that carries the swap may be stretched, so measure the next one.
    phase();
    phase();
    chk(n, 16);
    apb(1'b1, OFS_MODE_B, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_0011);
    rdchk(OFS_MODE_B, 32'h0000_0020);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    repeat (30) @(posedge mclk);
    apb(1'b1, OFS_MODE_A, 32'h0000_0000);
    phase();
    phase();
    chk(n, 8);
    // Stop: 2 x 2 ticks of 16 main edges, 4 cycles each, gives 256 cycles.
    apb(1'b1, OFS_TIMER, 32'h0000_0101);
    apb(1'b1, OFS_CMD, 32'h0000_0011);
    repeat (2) @(posedge mclk);
    chk({link.devState, mainOscEnable, subOscEnable, phiClock}, 7'b0100_001);
    extIrqTwo <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(link.devState, ST_STOP);
    extIrqTwo <= 1'b0;
    extIrqOne <= 1'b1;
    waitst(ST_WAKE);
    chk(n < 8, 1'b1);
    waitst(ST_RUN);
    chk({lowSeen, n >= 256 && n <= 300}, 2'b01);
    extIrqOne <= 1'b0;
    // Wait freezes the clock high; an enabled request ends it at once.
    apb(1'b1, OFS_CMD, 32'h0000_0012);
    waitst(ST_WAIT);
    lowSeen = 1'b0;
    repeat (30) begin
      @(posedge mclk);
      if (phiClock !== 1'b1) lowSeen = 1'b1;
    end
    chk({lowSeen, mainOscEnable}, 2'b01);
    extIrqOne <= 1'b1;
    waitst(ST_RUN);
    chk(n <= 6, 1'b1);
    extIrqOne <= 1'b0;
    // Oscillator output pin routing.
    singleChip <= 1'b1;
    syncFetch <= 1'b1;
    apb(1'b1, OFS_MODE_A, 32'h0000_0020);
    lowSeen = 1'b0;
    repeat (16) begin
      @(posedge mclk);
      if (oscOutPin === 1'b0) lowSeen = 1'b1;
    end
    chk(lowSeen, 1'b1);
    singleChip <= 1'b0;
    resetHighVolt <= 1'b1;
    apb(1'b1, OFS_MODE_A, 32'h0000_0000);
    repeat (5) @(posedge mclk);
    // The main oscillator keeps toggling, so a steady high proves the sync route.
    lowSeen = 1'b0;
    repeat (16) begin
      @(posedge mclk);
      if (oscOutPin !== 1'b1) lowSeen = 1'b1;
    end
    chk(lowSeen, 1'b0);
    syncFetch <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(oscOutPin, 1'b0);
    // Clock enable low freezes the whole block, so the CPU clock must not move.
    ce <= 1'b0;
    repeat (2) @(posedge mclk);
    frozenPhi = phiClock;
    lowSeen = 1'b0;
    repeat (20) begin
      @(posedge mclk);
      if (phiClock !== frozenPhi) lowSeen = 1'b1;
    end
    chk(lowSeen, 1'b0);
    ce <= 1'b1;
    // Device reset from the controller is held for the settle time.
    apb(1'b1, OFS_CMD, 32'h0000_0004);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(r & 32'h0000_0004, 32'h0000_0004);
    repeat (40) @(posedge mclk);
    // After release the block is back in run with its mode registers cleared.
    rdchk(OFS_STATUS, 32'h0000_0010);
    rdchk(OFS_MODE_B, 32'h0000_0000);
    final_report();
  end
endmodule // clock_power_mode_control_tb_top

// ===== verification/cpmc_asserts.sv
`timescale 1ns/100ps
// Watches the link between controller and clock block; both ends are design code.
module cpmc_asserts
  import cpmc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic stopInstr,
  input wire logic waitInstr,
  input wire logic [TMR_W-1:0] t1Load,
  input wire logic [2:0] irqEnable,
  input wire logic linkReset,
  input wire logic [3:0] devState,
  input wire logic [7:0] devModeA,
  input wire logic [7:0] devModeB
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_stop_enter: assert property (
    stopInstr && devState == ST_RUN && !linkReset |=> devState == ST_STOP)
    else $error("stop order did not reach stop state");
  a_wait_enter: assert property (
    waitInstr && !stopInstr && devState == ST_RUN && !linkReset |=> devState == ST_WAIT)
    else $error("wait order did not reach wait state");
  a_stop_irq_en: assert property (stopInstr |-> irqEnable != 3'b000)
    else $error("stop sent with no wake source enabled");
  a_wait_irq_en: assert property (waitInstr |-> irqEnable != 3'b000)
    else $error("wait sent with no wake source enabled");
  a_stop_no_disp: assert property (stopInstr |-> !devModeA[BIT_DISP_EN])
    else $error("stop sent while display enabled");
  a_stop_no_run: assert property (
    devState == ST_STOP && !linkReset |=> devState inside {ST_STOP, ST_WAKE})
    else $error("stop left without the wake count");
  a_wake_to_run: assert property (
    devState == ST_WAKE && !linkReset |=> devState inside {ST_WAKE, ST_RUN})
    else $error("wake count left to a wrong state");
  a_low_pwr_force: assert property (!devModeB[BIT_SUB_EN] |=> !devModeA[BIT_LOW_PWR])
    else $error("low power bit set with sub oscillator off");
  a_sub_kept: assert property (
    regWrite && regAddr == ADDR_MODE_B && devModeA[BIT_CLK_SEL] |-> regWdata[BIT_SUB_EN])
    else $error("sub oscillator disabled while selected");
  a_reset_held: assert property ($rose(linkReset) |=> linkReset [*8])
    else $error("device reset released too early");

  // Main scenarios that should be seen at least once.
  c_wake: cover property (devState == ST_WAKE ##1 devState == ST_RUN);
endmodule // cpmc_asserts
